// file: logic/vlsp_regs.svh
// offsets, field positions, reset values and fixed sizes of the level selector
`ifndef VLSP_REGS_SVH
`define VLSP_REGS_SVH

// register byte addresses
`define VLSP_ADDR_CTRL        32'h0000_0000
`define VLSP_ADDR_STATUS      32'h0000_0004

// control fields
`define VLSP_CTRL_SRC_BIT     0
`define VLSP_CTRL_SRC_RESET   1'b1

// status fields
`define VLSP_STAT_SRC_BIT     0
`define VLSP_STAT_STAGE_BIT   1
`define VLSP_STAT_EMPTY_BIT   2
`define VLSP_STAT_FULL_BIT    3
`define VLSP_STAT_CNT_LSB     4

// bus answers
`define VLSP_RESP_OKAY        2'h0
`define VLSP_RESP_SLVERR      2'h2

// pixel codes and sizes
`define VLSP_CODE_BLACK       4'h0
`define VLSP_CODE_WHITE       4'hF
`define VLSP_FIFO_DEPTH       8
`define VLSP_PAL_WORDS        16

`endif

// file: logic/vlsp_pkg.sv
// types shared by the level selector modules
package vlsp_pkg;

    // ************************************************
    // pixel side carriers
    // ************************************************

    // one strobe of controller inputs; index 0 red, 1 green, 2 blue
    typedef struct packed {
        logic             sync;
        logic             blank;
        logic             white;
        logic             bright;
        logic [3:0]       addr;
        logic [3:0]       data;
        logic [2:0]       write_n;
        logic [2:0][3:0]  pix;
    } vlsp_pix_t;

    // switch settings of one converter channel
    typedef struct packed {
        logic       sync_on;
        logic       blank_on;
        logic       bright_on;
        logic [3:0] code;
    } vlsp_level_t;

    // the three channels kept together for alignment
    typedef struct packed {
        vlsp_level_t red;
        vlsp_level_t green;
        vlsp_level_t blue;
    } vlsp_rgb_t;

    // pixel code source
    typedef enum logic {
        VLSP_SRC_DIRECT  = 1'b0,
        VLSP_SRC_PALETTE = 1'b1
    } vlsp_src_t;

    // ************************************************
    // state of the top module
    // ************************************************

    typedef struct packed {
        vlsp_pix_t              s_in;
        logic                   s_valid;
        vlsp_src_t              src;
        logic [2:0][15:0][3:0]  pal;
        logic                   aw_got;
        logic [31:0]            aw_addr;
        logic                   w_got;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } vlsp_top_st_t;

endpackage

// file: logic/vlsp_level_sel.sv
// priority level choice for one converter channel
`timescale 1ns/1ps
`include "vlsp_regs.svh"

module vlsp_level_sel #(
    parameter bit CARRIES_SYNC = 1'b0
) (
    input  logic                 sync,
    input  logic                 blank,
    input  logic                 white,
    input  logic                 bright,
    input  logic [3:0]           code,
    output vlsp_pkg::vlsp_level_t level
);

    // ************************************************
    // sync over blank over white over pixel code
    // ************************************************

    // brightness shifts every level, never overridden
    always_comb begin
        level           = '0;
        level.bright_on = bright;
        if (sync) begin
            // only the sync carrying channel adds the sync step
            level.sync_on  = CARRIES_SYNC;
            level.blank_on = 1'b1;
            level.code     = `VLSP_CODE_BLACK;
        end else if (blank) begin
            level.blank_on = 1'b1;
            level.code     = `VLSP_CODE_BLACK;
        end else if (white) begin
            level.code     = `VLSP_CODE_WHITE;
        end else begin
            // linear steps from black to white
            level.code     = code;
        end
    end

endmodule

// file: logic/vlsp_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps

module vlsp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  logic                       aclk,
    input  logic                       aresetn,
    input  logic                       in_valid,
    output logic                       in_ready,
    input  logic [WIDTH-1:0]           in_data,
    output logic                       out_valid,
    input  logic                       out_ready,
    output logic [WIDTH-1:0]           out_data,
    output logic [$clog2(DEPTH):0]     count
);

    localparam int AW = $clog2(DEPTH);

    // whole fifo state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } vlsp_fifo_st_t;

    vlsp_fifo_st_t st;       // registered state
    vlsp_fifo_st_t next_st;  // next state
    logic          push;     // word taken in
    logic          pop;      // word handed out

    // honest full and empty flags
    assign in_ready  = (st.cnt != DEPTH[AW:0]);
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];
    assign count     = st.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ************************************************
    // pointer and storage update
    // ************************************************

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// file: logic/vlsp_top.sv
// palette level selector with axi4-lite control and output fifo
`timescale 1ns/1ps
`include "vlsp_regs.svh"

module vlsp_top (
    input  logic                 aclk,
    input  logic                 aresetn,
    // axi4-lite write address
    input  logic [31:0]          s_axi_awaddr,
    input  logic [2:0]           s_axi_awprot,
    input  logic                 s_axi_awvalid,
    output logic                 s_axi_awready,
    // axi4-lite write data
    input  logic [31:0]          s_axi_wdata,
    input  logic [3:0]           s_axi_wstrb,
    input  logic                 s_axi_wvalid,
    output logic                 s_axi_wready,
    // axi4-lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  logic                 s_axi_bready,
    // axi4-lite read address
    input  logic [31:0]          s_axi_araddr,
    input  logic [2:0]           s_axi_arprot,
    input  logic                 s_axi_arvalid,
    output logic                 s_axi_arready,
    // axi4-lite read data
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  logic                 s_axi_rready,
    // controller strobe inputs
    input  logic                 pix_valid,
    output logic                 pix_ready,
    input  vlsp_pkg::vlsp_pix_t  pix_in,
    // levels toward the converters
    output logic                 level_valid,
    input  logic                 level_ready,
    output vlsp_pkg::vlsp_rgb_t  level_out
);

    // ************************************************
    // declarations
    // ************************************************

    localparam int CW = $clog2(`VLSP_FIFO_DEPTH) + 1;

    vlsp_pkg::vlsp_top_st_t st;        // registered state
    vlsp_pkg::vlsp_top_st_t next_st;   // next state
    vlsp_pkg::vlsp_level_t  lvl [3];   // per channel choice
    vlsp_pkg::vlsp_rgb_t    sel_rgb;   // aligned triple
    logic [2:0][3:0]        code;      // code fed to selectors
    logic                   accept;    // strobe taken this edge
    logic                   fifo_ready;// fifo can take a word
    logic [CW-1:0]          fifo_cnt;  // words in fifo
    logic                   aw_hit;    // decoded write address
    logic [31:0]            wr_addr;   // aligned write address
    logic [31:0]            rd_addr;   // aligned read address
    logic [31:0]            status;    // live status word

    // ************************************************
    // input stage and code source
    // ************************************************

    // stage frees when empty or when the fifo takes its word
    assign pix_ready = !st.s_valid || fifo_ready;
    assign accept    = pix_valid && pix_ready;

    // per channel code mux and level choice
    for (genvar c = 0; c < 3; c++) begin : g_chan
        assign code[c] = (st.src == vlsp_pkg::VLSP_SRC_PALETTE)
                       ? st.pal[c][st.s_in.addr]
                       : st.s_in.pix[c];

        vlsp_level_sel #(
            .CARRIES_SYNC (c == 1)
        ) u_sel (
            .sync   (st.s_in.sync),
            .blank  (st.s_in.blank),
            .white  (st.s_in.white),
            .bright (st.s_in.bright),
            .code   (code[c]),
            .level  (lvl[c])
        );
    end

    assign sel_rgb.red   = lvl[0];
    assign sel_rgb.green = lvl[1];
    assign sel_rgb.blue  = lvl[2];

    // ************************************************
    // output fifo
    // ************************************************

    // levels held in flops until the converters take them
    vlsp_fifo #(
        .WIDTH ($bits(vlsp_pkg::vlsp_rgb_t)),
        .DEPTH (`VLSP_FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (st.s_valid),
        .in_ready  (fifo_ready),
        .in_data   (sel_rgb),
        .out_valid (level_valid),
        .out_ready (level_ready),
        .out_data  (level_out),
        .count     (fifo_cnt)
    );

    // ************************************************
    // bus decode helpers
    // ************************************************

    assign wr_addr = {st.aw_addr[31:2], 2'b00};
    assign rd_addr = {s_axi_araddr[31:2], 2'b00};
    assign aw_hit  = (wr_addr == `VLSP_ADDR_CTRL)
                  || (wr_addr == `VLSP_ADDR_STATUS);

    // status word from live block state
    always_comb begin
        status = '0;
        status[`VLSP_STAT_SRC_BIT]   = st.src;
        status[`VLSP_STAT_STAGE_BIT] = st.s_valid;
        status[`VLSP_STAT_EMPTY_BIT] = !level_valid;
        status[`VLSP_STAT_FULL_BIT]  = !fifo_ready;
        status[`VLSP_STAT_CNT_LSB +: CW] = fifo_cnt;
    end

    // handshake outputs
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready  = !st.w_got && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // ************************************************
    // next state
    // ************************************************

    always_comb begin
        next_st = st;

        // sample strobe inputs on the clock edge
        if (pix_ready) begin
            next_st.s_valid = pix_valid;
        end
        if (accept) begin
            next_st.s_in = pix_in;
        end

        // active low enables store the data word
        for (int c = 0; c < 3; c++) begin
            if (accept && !pix_in.write_n[c]) begin
                next_st.pal[c][pix_in.addr] = pix_in.data;
            end
        end

        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // both halves present: commit and answer
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = aw_hit ? `VLSP_RESP_OKAY
                                    : `VLSP_RESP_SLVERR;
            if (wr_addr == `VLSP_ADDR_CTRL && st.w_strb[0]) begin
                // source select steers the code mux
                next_st.src = vlsp_pkg::vlsp_src_t'(
                    st.w_data[`VLSP_CTRL_SRC_BIT]);
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // read answer one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `VLSP_RESP_OKAY;
            if (rd_addr == `VLSP_ADDR_CTRL) begin
                next_st.rdata = {31'h0000_0000, st.src};
            end else if (rd_addr == `VLSP_ADDR_STATUS) begin
                next_st.rdata = status;
            end else begin
                next_st.rdata = 32'h0000_0000;
                next_st.rresp = `VLSP_RESP_SLVERR;
            end
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    // ************************************************
    // state register
    // ************************************************

    // synchronous reset, palette starts cleared
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st     <= '0;
            st.src <= vlsp_pkg::vlsp_src_t'(`VLSP_CTRL_SRC_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ************************************************
    // assertions
    // ************************************************

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_SYNC_GREEN: assert property (
        st.s_valid && st.s_in.sync |->
            lvl[1].sync_on && lvl[1].blank_on
            && lvl[1].code == 4'h0
            && lvl[1].bright_on == st.s_in.bright
    ) else $error("green not at sync level during sync");

    AST_SYNC_RB: assert property (
        st.s_in.sync |->
            !lvl[0].sync_on && !lvl[2].sync_on
            && lvl[0].blank_on && lvl[2].blank_on
            && lvl[0].bright_on == st.s_in.bright
    ) else $error("red or blue carries sync");

    AST_BLANK: assert property (
        !st.s_in.sync && st.s_in.blank |->
            lvl[0].blank_on && lvl[1].blank_on && lvl[2].blank_on
            && !lvl[1].sync_on && lvl[1].code == 4'h0
    ) else $error("blank level not selected");

    AST_WHITE: assert property (
        !st.s_in.sync && !st.s_in.blank && st.s_in.white |->
            lvl[0].code == 4'hF && lvl[1].code == 4'hF
            && lvl[2].code == 4'hF && !lvl[2].blank_on
    ) else $error("white level not selected");

    // code passes through with bright offset
    AST_CODE_PASS: assert property (
        !st.s_in.sync && !st.s_in.blank && !st.s_in.white |->
            lvl[2].code == code[2] && !lvl[2].blank_on
            && lvl[2].bright_on == st.s_in.bright
    ) else $error("pixel code not passed to level");

    AST_PAL_READ: assert property (
        st.src == vlsp_pkg::VLSP_SRC_PALETTE
        && !st.s_in.sync && !st.s_in.blank && !st.s_in.white |->
            lvl[1].code == st.pal[1][st.s_in.addr]
    ) else $error("palette word not used");

    AST_DIRECT: assert property (
        st.src == vlsp_pkg::VLSP_SRC_DIRECT
        && !st.s_in.sync && !st.s_in.blank && !st.s_in.white |->
            lvl[0].code == st.s_in.pix[0]
    ) else $error("direct code not used");

    AST_PAL_WRITE: assert property (
        accept && !pix_in.write_n[2] |=>
            st.pal[2][$past(pix_in.addr)] == $past(pix_in.data)
    ) else $error("palette write lost");

    AST_SAMPLE: assert property (
        accept |=> st.s_valid && st.s_in == $past(pix_in)
    ) else $error("strobe inputs not sampled");

    // write response stands until taken
    AST_BHOLD: assert property (
        st.bvalid && !s_axi_bready |=> st.bvalid && $stable(st.bresp)
    ) else $error("write response dropped early");

    // read answer one cycle after the address
    AST_RANSWER: assert property (
        s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid
    ) else $error("read answer late");

endmodule

// file: testbench/vlsp_ctl_model.sv
// display controller model that offers pixel strobes
`timescale 1ns/1ps

module vlsp_ctl_model (
    input  logic                 aclk,
    input  logic                 aresetn,
    input  logic                 slow,
    input  logic                 pix_ready,
    output vlsp_pkg::vlsp_pix_t  pix_in,
    output logic                 pix_valid
);
    vlsp_pkg::vlsp_pix_t q[$];   // strobes waiting to go out
    logic                gap;    // idle cycle owed in slow mode

    // queue one strobe for the offer loop
    task automatic send(input vlsp_pkg::vlsp_pix_t p);
        q.push_back(p);
    endtask

    // ************************************************
    // offer loop
    // ************************************************
    // held until taken, low enables store
    initial begin
        pix_valid = 1'b0;
        pix_in    = '0;
        gap       = 1'b0;
        forever begin
            @(posedge aclk);
            if (!aresetn) begin
                pix_valid <= 1'b0;
            end else if (pix_valid && !pix_ready) begin
                // refused: hold everything
            end else if (q.size() > 0 && !gap) begin
                pix_in    <= q.pop_front();
                pix_valid <= 1'b1;
                gap       = slow;
            end else begin
                // released lines change pattern
                pix_valid <= 1'b0;
                pix_in    <= ~pix_in;
                gap       = 1'b0;
            end
        end
    end
endmodule

// file: testbench/test_vlsp_top.sv
// self-checking bench for the palette level selector
`timescale 1ns/1ps
`include "vlsp_regs.svh"

module test_vlsp_top;
    logic                 aclk, aresetn, slow;
    logic [31:0]          s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic [31:0]          s_axi_rdata;
    logic [2:0]           s_axi_awprot, s_axi_arprot;
    logic [3:0]           s_axi_wstrb;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                 s_axi_rready, pix_valid, pix_ready;
    logic                 level_valid, level_ready;
    vlsp_pkg::vlsp_pix_t  pix_in;
    vlsp_pkg::vlsp_rgb_t  level_out;
    logic [2:0][15:0][3:0] pal_m;    // palette as expected
    vlsp_pkg::vlsp_rgb_t  exp_q[$];  // expected triples in order
    logic                 cur_src;   // expected source select
    logic [31:0]          seed, seed_r;
    logic [1:0]           rdy_mode;  // 0 stall, 1 ready, 2 random
    int                   bad_count, samples_checked;

    vlsp_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pix_valid, .pix_ready, .pix_in, .level_valid,
        .level_ready, .level_out);
    vlsp_ctl_model i_ctl (.aclk, .aresetn, .slow, .pix_ready, .pix_in,
        .pix_valid);

    // ************************************************
    // expectation helpers
    // ************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {1'b0, s[31:1]} ^ ({32{s[0]}} & 32'h8020_0003);
    endfunction

    // priority choice per channel
    function automatic vlsp_pkg::vlsp_rgb_t exp_lv(
        input vlsp_pkg::vlsp_pix_t p, input logic src);
        vlsp_pkg::vlsp_level_t l [3];
        logic [3:0]            code;
        for (int c = 0; c < 3; c++) begin
            code = src ? pal_m[c][p.addr] : p.pix[c];
            l[c] = '{1'b0, 1'b0, p.bright, code};
            if (p.sync || p.blank) begin
                l[c] = '{p.sync && c == 1, 1'b1, p.bright, 4'h0};
            end else if (p.white) begin
                l[c].code = 4'hF;
            end
        end
        exp_lv = {l[0], l[1], l[2]};
    endfunction

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // ************************************************
    // bus tasks
    // ************************************************
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        check(s_axi_rdata === ed && s_axi_rresp === er, "register read");
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        check(n < 100 && s_axi_bresp === er, "write response");
        s_axi_bready <= 1'b0;
    endtask

    // ************************************************
    // stimulus tasks
    // ************************************************
    task automatic send_rand(input int n);
        vlsp_pkg::vlsp_pix_t p;
        logic [31:0]         x;
        repeat (n) begin
            seed = lfsr(lfsr(seed));
            p    = seed[30:0];
            x    = lfsr(lfsr(lfsr(seed)));
            p.sync    = x[2:0] == 3'h0;
            p.blank   = x[5:3] == 3'h0;
            p.white   = x[8:6] == 3'h0;
            p.write_n = x[11:9] | {3{x[12]}};
            i_ctl.send(p);
        end
    endtask

    // sync, blank, white, black, white code, both brightness levels
    task automatic send_corners();
        vlsp_pkg::vlsp_pix_t p;
        for (int i = 0; i < 10; i++) begin
            p = '0;
            p.write_n = 3'h7;
            p.bright  = i[0];
            p.sync    = i / 2 == 0;
            p.blank   = i / 2 == 1;
            p.white   = i / 2 == 2;
            p.pix     = (i < 4 || i > 7) ? 12'hFFF : 12'h000;
            i_ctl.send(p);
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() > 0 || i_ctl.q.size() > 0) && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        repeat (3) @(posedge aclk);
        check(n < 3000 && level_valid === 1'b0, "stream stalled");
    endtask

    task automatic end_test(input string name);
        $display("test %s ended, %0d mismatches", name, bad_count);
    endtask

    task automatic test_done();
        $display("checked %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ************************************************
    // monitors and drivers
    // ************************************************
    // track stores and compare every popped triple
    always @(posedge aclk) begin
        if (aresetn && pix_valid && pix_ready) begin
            for (int c = 0; c < 3; c++) begin
                if (!pix_in.write_n[c]) pal_m[c][pix_in.addr] = pix_in.data;
            end
            exp_q.push_back(exp_lv(pix_in, cur_src));
        end
        if (aresetn && level_valid && level_ready) begin
            check(exp_q.size() > 0 && level_out === exp_q[0], "level");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end

    // converter side acceptance, may stall
    always @(posedge aclk) begin
        seed_r      <= lfsr(seed_r);
        level_ready <= rdy_mode == 2'h1 || (rdy_mode == 2'h2 && seed_r[0]);
    end

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (50000) @(posedge aclk);
        bad_count++;
        $display("unexpected at %0t: run hung", $time);
        test_done();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = '0;
        s_axi_wstrb = 4'hF;
        level_ready = 1'b0;
        {bad_count, samples_checked} = '0;
        {seed, seed_r} = {32'h0000_0004, 32'h0000_0004};
        for (int k = 0; k < 2; k++) begin
            pal_m    = '0;
            cur_src  = 1'b1;
            rdy_mode = 2'h1;
            aresetn  = 1'b0;
            repeat (3) @(posedge aclk);
            aresetn <= 1'b1;
            rd_chk(`VLSP_ADDR_CTRL, 32'h0000_0001, `VLSP_RESP_OKAY);
            rd_chk(`VLSP_ADDR_STATUS, 32'h0000_0005, `VLSP_RESP_OKAY);
        end
        rd_chk(32'h0000_0010, 32'h0000_0000, `VLSP_RESP_SLVERR);
        wr_chk(32'h0000_0010, 32'h0000_0000, `VLSP_RESP_SLVERR);
        wr_chk(`VLSP_ADDR_STATUS, 32'hFFFF_FFFF, `VLSP_RESP_OKAY);
        rd_chk(`VLSP_ADDR_CTRL, 32'h0000_0001, `VLSP_RESP_OKAY);
        end_test("registers");
        rdy_mode <= 2'h2;
        send_corners();
        send_rand(300);
        drain();
        end_test("palette");
        wr_chk(`VLSP_ADDR_CTRL, 32'h0000_0000, `VLSP_RESP_OKAY);
        cur_src = 1'b0;
        rd_chk(`VLSP_ADDR_CTRL, 32'h0000_0000, `VLSP_RESP_OKAY);
        slow = 1'b1;
        send_corners();
        send_rand(200);
        drain();
        slow = 1'b0;
        end_test("direct");
        rdy_mode <= 2'h0;
        send_rand(12);
        repeat (30) @(posedge aclk);
        check(pix_ready === 1'b0, "full stage not refused");
        rd_chk(`VLSP_ADDR_STATUS, 32'h0000_008A, `VLSP_RESP_OKAY);
        rdy_mode <= 2'h1;
        drain();
        rd_chk(`VLSP_ADDR_STATUS, 32'h0000_0004, `VLSP_RESP_OKAY);
        end_test("fifo");
        test_done();
    end
endmodule
